/* File: src/sleep_wake_and_watchdog.sv */
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/1ns
`include "sleep_wake_map.svh"
module sleep_wake_and_watchdog #(
  parameter int OSC_KHZ = `WDT_OSC_KHZ
) (
  // clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   reset,
  // register port
  input  wire logic [3:0]             regAddr,
  input  wire sleep_wake_pkg::byte_type regWdata,
  input  wire logic                   regWrite,
  input  wire logic                   regRead,
  output sleep_wake_pkg::byte_type    regRdata,
  // core instruction events
  input  wire logic                   sleepExec,
  input  wire logic                   clrWdtExec,
  output logic                        cpuClkEn,
  output logic                        prefetchNext,
  output logic                        wakeResume,
  output logic                        wakeToIsr,
  output logic [12:0]                 isrAddr,
  output logic                        coreReset,
  // configuration fuses
  input  wire logic                   watchdogFuseEnable,
  input  wire logic                   resetPinEnable,
  // asynchronous pins and events
  input  wire logic                   wdtOsc,
  input  wire logic                   externalResetPinN,
  input  wire logic                   porEvent,
  input  wire logic                   brownoutReset,
  input  wire logic                   extIrqPin,
  input  wire sleep_wake_pkg::byte_type portA,
  input  wire sleep_wake_pkg::byte_type portB,
  // same-clock interrupt sources
  input  wire logic                   timer0Overflow,
  input  wire sleep_wake_pkg::byte_type periphSet1,
  input  wire sleep_wake_pkg::byte_type periphSet2,
  // pin drive from port logic and to pads
  input  wire sleep_wake_pkg::byte_type portOut,
  input  wire sleep_wake_pkg::byte_type portOeN,
  output sleep_wake_pkg::byte_type    pinOut,
  output sleep_wake_pkg::byte_type    pinOeN,
  // analog supply
  output logic                        analogSupplyEn
);
  import sleep_wake_pkg::*;

  localparam int TIMEOUT_TICKS = `WDT_PERIOD_US * OSC_KHZ / `US_PER_MS;

  state_type state;
  byte_type  option;
  byte_type  coreStatus;
  byte_type  intCtl;
  byte_type  pchgEnA;
  byte_type  pchgEnB;
  byte_type  peripheral_irq_enable_1;
  byte_type  peripheral_irq_enable_2;
  byte_type  peripheral_irq_flags_1;
  byte_type  peripheral_irq_flags_2;

  //////////////////////////////////////////////////////////////////////
  // three-flop synchronisers; stage one feeds stage two only
  localparam int NSYNC = 21;
  logic [NSYNC-1:0] asyncIn;
  logic [NSYNC-1:0] syncA;
  logic [NSYNC-1:0] syncB;
  logic [NSYNC-1:0] syncC;

  assign asyncIn = {portB, portA, extIrqPin, brownoutReset, porEvent,
                    externalResetPinN, wdtOsc};

  genvar g;
  generate
    for (g = 0; g < NSYNC; g++) begin : gSync
      always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
          syncA[g] <= 1'b0;
          syncB[g] <= 1'b0;
          syncC[g] <= 1'b0;
        end else begin
          syncA[g] <= asyncIn[g];
          syncB[g] <= syncA[g];
          syncC[g] <= syncB[g];
        end
      end
    end
  endgenerate

  logic     oscTick;
  logic     pinReset;
  logic     porSeen;
  logic     borSeen;
  logic     extEdge;
  byte_type chgA;
  byte_type chgB;

  assign oscTick  = syncB[0] && !syncC[0];
  // reset pin starts low in the chain, so a falling edge is the event
  assign pinReset = resetPinEnable && !syncB[1] && syncC[1];
  assign porSeen  = syncB[2] && !syncC[2];
  assign borSeen  = syncB[3] && !syncC[3];
  assign extEdge  = option[`EDGE_BIT] ? (syncB[4] && !syncC[4])
                                      : (!syncB[4] && syncC[4]);
  assign chgA     = syncB[12:5] ^ syncC[12:5];
  assign chgB     = syncB[20:13] ^ syncC[20:13];

  //////////////////////////////////////////////////////////////////////
  // wake qualification
  logic pendingIrq;
  logic wdtTimeout;
  logic hardReset;
  logic sleepTake;
  logic sleepNop;
  logic wakeIrq;
  logic wakeAny;

  // global enable is not part of the wake term
  assign pendingIrq =
      (intCtl[`EXTIE_BIT] && intCtl[`EXTIF_BIT]) ||
      (intCtl[`PCHGIE_BIT] && intCtl[`PCHGIF_BIT]) ||
      (intCtl[`T0IE_BIT] && intCtl[`T0IF_BIT]) ||
      (intCtl[`PEIE_BIT] && |((peripheral_irq_enable_1 & peripheral_irq_flags_1) | (peripheral_irq_enable_2 & peripheral_irq_flags_2)));

  assign hardReset = pinReset || porSeen;
  assign sleepNop  = !intCtl[`GIE_BIT] && pendingIrq;
  assign sleepTake = (state == RUN) && sleepExec && !sleepNop;
  // a flag that rises after the take is seen here next cycle
  assign wakeIrq   = (state == DOZE) && pendingIrq;
  assign wakeAny   = (state == DOZE) && (wakeIrq || wdtTimeout || hardReset);

  //////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state <= RUN;
    end else begin
      unique case (state)
        RUN: begin
          if (sleepTake && !hardReset) begin
            state <= DOZE;
          end
        end
        DOZE: begin
          if (wakeAny) begin
            state <= RUN;
          end
        end
      endcase
    end
  end

  // the processor clock and analog rail follow the state flop directly
  assign cpuClkEn       = (state == RUN);
  assign analogSupplyEn = (state == RUN);

  //////////////////////////////////////////////////////////////////////
  // watchdog
  logic wdtClear;

  assign wdtClear = clrWdtExec || sleepTake || wakeAny;

  watchdog_core #(
    .TIMEOUT_TICKS (TIMEOUT_TICKS)
  ) uWatchdog (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .tick     (oscTick),
    .enable   (watchdogFuseEnable),
    .clear    (wdtClear),
    .scaleOn  (option[`PSA_BIT]),
    .scaleSel (option[`PS_HI:`PS_LO]),
    .timeout  (wdtTimeout)
  );

  //////////////////////////////////////////////////////////////////////
  // core-facing pulses
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      prefetchNext <= 1'b0;
      wakeResume   <= 1'b0;
      wakeToIsr    <= 1'b0;
      coreReset    <= 1'b0;
      isrAddr      <= `ISR_VECTOR;
    end else begin
      prefetchNext <= (state == RUN) && sleepExec;
      wakeResume   <= wakeAny && !hardReset;
      wakeToIsr    <= wakeIrq && !hardReset &&
                      intCtl[`GIE_BIT];
      // brownout and pin reset act the same asleep or awake
      coreReset    <= hardReset || borSeen ||
                      (wdtTimeout && state == RUN);
      isrAddr      <= `ISR_VECTOR;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // frozen pad drive; the port latches may move but the pads do not
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pinOut <= `ZERO_RST;
      pinOeN <= `OPTION_RST;
    end else if (state == RUN && !sleepTake) begin
      pinOut <= portOut;
      pinOeN <= portOeN;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // register writes
  logic wrOption;
  logic wrStatus;
  logic wrIntCtl;
  logic wrPir1;
  logic wrPir2;

  assign wrOption = regWrite && regAddr == `REG_OPTION;
  assign wrStatus = regWrite && regAddr == `REG_STATUS;
  assign wrIntCtl = regWrite && regAddr == `REG_INTCTL;
  assign wrPir1   = regWrite && regAddr == `REG_PERIPHERAL_IRQ_FLAGS_1;
  assign wrPir2   = regWrite && regAddr == `REG_PERIPHERAL_IRQ_FLAGS_2;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      option <= `OPTION_RST;
    end else if (wrOption) begin
      option <= regWdata;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pchgEnA <= `ZERO_RST;
      pchgEnB <= `ZERO_RST;
      peripheral_irq_enable_1    <= `ZERO_RST;
      peripheral_irq_enable_2    <= `ZERO_RST;
    end else if (regWrite) begin
      if (regAddr == `REG_PCHG_A) begin
        pchgEnA <= regWdata & `PCHG_A_MASK;
      end
      if (regAddr == `REG_PCHG_B) begin
        pchgEnB <= regWdata & `PCHG_B_MASK;
      end
      if (regAddr == `REG_PERIPHERAL_IRQ_ENABLE_1) begin
        peripheral_irq_enable_1 <= regWdata;
      end
      if (regAddr == `REG_PERIPHERAL_IRQ_ENABLE_2) begin
        peripheral_irq_enable_2 <= regWdata & `PERIPHERAL_IRQ_ENABLE_2_MASK;
      end
    end
  end

  // hardware set wins over a software write in the same cycle
  byte_type intSet;

  always_comb begin
    intSet              = `ZERO_RST;
    intSet[`T0IF_BIT]   = timer0Overflow;
    intSet[`EXTIF_BIT]  = extEdge;
    intSet[`PCHGIF_BIT] = |((chgA & pchgEnA) |
                            (chgB & pchgEnB));
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      intCtl <= `ZERO_RST;
    end else begin
      intCtl <= (wrIntCtl ? regWdata : intCtl) | intSet;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      peripheral_irq_flags_1 <= `ZERO_RST;
      peripheral_irq_flags_2 <= `ZERO_RST;
    end else begin
      peripheral_irq_flags_1 <= (wrPir1 ? regWdata : peripheral_irq_flags_1) | periphSet1;
      peripheral_irq_flags_2 <= ((wrPir2 ? regWdata : peripheral_irq_flags_2) | periphSet2) & `PERIPHERAL_IRQ_ENABLE_2_MASK;
    end
  end

  // expiry and power-down are hardware owned; other bits plain storage
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      coreStatus <= `STATUS_RST;
    end else begin
      if (wrStatus) begin
        coreStatus[7:5] <= regWdata[7:5];
        coreStatus[2:0] <= regWdata[2:0];
      end
      if (wdtTimeout) begin
        coreStatus[`EXPIRY_BIT] <= 1'b0;
      end else if (sleepTake) begin
        coreStatus[`EXPIRY_BIT] <= 1'b1;
      end
      if (sleepTake) begin
        coreStatus[`PWRDN_BIT] <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // read data one cycle after the strobe, zero elsewhere
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      regRdata <= `ZERO_RST;
    end else if (regRead) begin
      unique case (regAddr)
        `REG_OPTION: regRdata <= option;
        `REG_STATUS: regRdata <= coreStatus;
        `REG_INTCTL: regRdata <= intCtl;
        `REG_PCHG_A: regRdata <= pchgEnA;
        `REG_PCHG_B: regRdata <= pchgEnB;
        `REG_PERIPHERAL_IRQ_ENABLE_1:   regRdata <= peripheral_irq_enable_1;
        `REG_PERIPHERAL_IRQ_ENABLE_2:   regRdata <= peripheral_irq_enable_2;
        `REG_PERIPHERAL_IRQ_FLAGS_1:   regRdata <= peripheral_irq_flags_1;
        `REG_PERIPHERAL_IRQ_FLAGS_2:   regRdata <= peripheral_irq_flags_2;
        default:     regRdata <= `ZERO_RST;
      endcase
    end else begin
      regRdata <= `ZERO_RST;
    end
  end
endmodule

/* File: src/sleep_wake_map.svh */
`ifndef SLEEP_WAKE_MAP_SVH
`define SLEEP_WAKE_MAP_SVH
// register indices on the plain register port
`define REG_OPTION       4'h0
`define REG_STATUS       4'h1
`define REG_INTCTL       4'h2
`define REG_PCHG_A       4'h3
`define REG_PCHG_B       4'h4
`define REG_PERIPHERAL_IRQ_ENABLE_1         4'h5
`define REG_PERIPHERAL_IRQ_ENABLE_2         4'h6
`define REG_PERIPHERAL_IRQ_FLAGS_1         4'h7
`define REG_PERIPHERAL_IRQ_FLAGS_2         4'h8
// interrupt_control fields
`define GIE_BIT          7
`define PEIE_BIT         6
`define T0IE_BIT         5
`define EXTIE_BIT        4
`define PCHGIE_BIT       3
`define T0IF_BIT         2
`define EXTIF_BIT        1
`define PCHGIF_BIT       0
// core_status fields
`define EXPIRY_BIT       4
`define PWRDN_BIT        3
// option fields
`define EDGE_BIT         6
`define PSA_BIT          3
`define PS_HI            2
`define PS_LO            0
// reset values and implemented-bit masks
`define ZERO_RST         8'h00
`define STATUS_RST       8'h18
`define OPTION_RST       8'hFF
`define PCHG_A_MASK      8'hEF
`define PCHG_B_MASK      8'hF3
`define PERIPHERAL_IRQ_ENABLE_2_MASK        8'hDF
// timing and vector
`define WDT_PERIOD_US    18000
`define WDT_OSC_KHZ      31
`define US_PER_MS        1000
`define ISR_VECTOR       13'h0004
`endif

/* File: src/sleep_wake_pkg.sv */
package sleep_wake_pkg;
  typedef logic [7:0] byte_type;
  typedef logic [2:0] scale_type;
  typedef enum logic [0:0] {
    RUN  = 1'b0,
    DOZE = 1'b1
  } state_type;
endpackage

/* File: src/watchdog_core.sv */
`timescale 1ns/1ns
module watchdog_core #(
  parameter int TIMEOUT_TICKS = 558
) (
  // clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    reset,
  // control
  input  wire logic                    tick,
  input  wire logic                    enable,
  input  wire logic                    clear,
  input  wire logic                    scaleOn,
  input  wire sleep_wake_pkg::scale_type scaleSel,
  // result
  output logic                         timeout
);
  import sleep_wake_pkg::*;

  localparam int CW = $clog2(TIMEOUT_TICKS);

  logic [6:0]    preCount;
  logic [CW-1:0] baseCount;
  logic [6:0]    preLimit;
  logic          baseStep;

  // ratio 1:2^sel only while the scaler belongs to the watchdog
  assign preLimit = scaleOn ? 7'((8'h01 << scaleSel) - 8'h01) : 7'h00;
  assign baseStep = tick && (preCount >= preLimit);

  //////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      preCount <= 7'h00;
    end else if (clear || !enable) begin
      preCount <= 7'h00;
    end else if (baseStep) begin
      preCount <= 7'h00;
    end else if (tick) begin
      preCount <= preCount + 7'h01;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      baseCount <= '0;
      timeout   <= 1'b0;
    end else if (clear || !enable) begin
      baseCount <= '0;
      timeout   <= 1'b0;
    end else if (baseStep && baseCount == CW'(TIMEOUT_TICKS - 1)) begin
      baseCount <= '0;
      timeout   <= 1'b1;
    end else begin
      if (baseStep) begin
        baseCount <= baseCount + CW'(1);
      end
      timeout <= 1'b0;
    end
  end
endmodule

/* File: test/sleep_wake_and_watchdog_tb.sv */
`timescale 1ns/1ns
`include "sleep_wake_map.svh"
module sleep_wake_and_watchdog_tb;
  import sleep_wake_pkg::*;
  logic        ref_clk, reset, regWrite, regRead, sleepExec;
  logic        clrWdtExec, watchdogFuseEnable, resetPinEnable, wdtOsc;
  logic        externalResetPinN, porEvent, brownoutReset, extIrqPin;
  logic        timer0Overflow, cpuClkEn, prefetchNext, wakeResume;
  logic        wakeToIsr, coreReset, analogSupplyEn, wk, cr, it;
  logic [3:0]  regAddr;
  logic [12:0] isrAddr;
  byte_type    regWdata, regRdata, portA, portB, periphSet1, periphSet2;
  byte_type    portOut, portOeN, pinOut, pinOeN, frz, rdv;
  logic [31:0] seed = 32'h9110CCF2;
  int          fails = 0, nTests = 0, expStatus, n;

  sleep_wake_and_watchdog #(.OSC_KHZ(1)) dut_u (.ref_clk, .reset,
    .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .sleepExec,
    .clrWdtExec, .cpuClkEn, .prefetchNext, .wakeResume, .wakeToIsr,
    .isrAddr, .coreReset, .watchdogFuseEnable, .resetPinEnable, .wdtOsc,
    .externalResetPinN, .porEvent, .brownoutReset, .extIrqPin, .portA,
    .portB, .timer0Overflow, .periphSet1, .periphSet2, .portOut,
    .portOeN, .pinOut, .pinOeN, .analogSupplyEn);
  //////////////////////////////////////////////////////////////////////////
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task chk(input logic [15:0] s, input logic [15:0] e);
    nTests++;
    if (s !== e) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task end_of_test();
    $display("comparisons %0d mismatches %0d", nTests, fails);
    if (fails == 0 && nTests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // sample at the falling edge so registered pulses are settled
  task step();
    @(negedge ref_clk);
    if (wakeResume === 1'b1) begin
      wk = 1;
      it = wakeToIsr;
    end
    if (coreReset === 1'b1) cr = 1;
    rdv = regRdata;
    @(posedge ref_clk);
  endtask
  // a gap cycle after each strobe keeps one assignment per time step
  task wr(input logic [3:0] a, input byte_type d);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    step();
    regWrite <= 1'b0;
    step();
  endtask
  task rd(input logic [3:0] a, input byte_type e);
    regAddr <= a;
    regRead <= 1'b1;
    step();
    regRead <= 1'b0;
    step();
    chk(rdv, e);
  endtask
  // long tick leaves room for the synchroniser and the wake pulse
  task tick();
    wdtOsc <= 1'b1;
    repeat (6) step();
    wdtOsc <= 1'b0;
    repeat (6) step();
  endtask
  task goSleep(input logic taken);
    portOut <= byte_type'(xs());
    portOeN <= byte_type'(xs());
    step();
    step();
    frz = portOut;
    sleepExec <= 1'b1;
    @(posedge ref_clk);
    sleepExec <= 1'b0;
    @(negedge ref_clk);
    chk(prefetchNext, 1'b1);
    chk(cpuClkEn, !taken);
    chk(analogSupplyEn, !taken);
    @(posedge ref_clk);
    portOut <= ~frz;
    step();
    @(negedge ref_clk);
    if (taken) chk(pinOut, frz);
    @(posedge ref_clk);
    if (taken) expStatus = 'h10;
    wk = 0;
    cr = 0;
    it = 0;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (40000) @(posedge ref_clk);
    fails++;
    end_of_test();
  end
  initial begin
    {reset, watchdogFuseEnable, resetPinEnable, externalResetPinN} = 4'hF;
    {regWrite, regRead, sleepExec, clrWdtExec, wdtOsc} = 5'h00;
    {porEvent, brownoutReset, extIrqPin, timer0Overflow} = 4'h0;
    {regAddr, regWdata, portA, portB} = 28'h0000000;
    {periphSet1, periphSet2, portOut, portOeN} = 32'h000000FF;
    expStatus = 'h18;
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    step();
    rd(`REG_STATUS, expStatus);
    rd(`REG_OPTION, 8'hFF);
    rd(4'hF, 8'h00);
    $display("test reset values done");
    wr(`REG_INTCTL, 8'h12);
    goSleep(1'b0);
    rd(`REG_STATUS, expStatus);
    $display("test pending sleep done");
    for (int i = 0; i < 5; i++) begin
      case (i)
        0: wr(`REG_INTCTL, 8'h90);
        1: begin
          wr(`REG_PCHG_A, 8'h01);
          wr(`REG_INTCTL, 8'h08);
        end
        2: begin
          wr(`REG_PCHG_B, 8'h02);
          wr(`REG_INTCTL, 8'h88);
        end
        3: wr(`REG_INTCTL, 8'h20);
        default: begin
          wr(`REG_PERIPHERAL_IRQ_ENABLE_1, 8'h01);
          wr(`REG_INTCTL, 8'hC0);
        end
      endcase
      goSleep(1'b1);
      case (i)
        0: extIrqPin <= 1'b1;
        1: portA <= 8'h01;
        2: portB <= 8'h02;
        3: timer0Overflow <= 1'b1;
        default: periphSet1 <= 8'h01;
      endcase
      step();
      timer0Overflow <= 1'b0;
      periphSet1 <= 8'h00;
      repeat (12) if (!wk) step();
      chk(wk, 1'b1);
      chk(it, i % 2 == 0);
      rd(`REG_STATUS, expStatus);
    end
    $display("test interrupt wake done");
    wr(`REG_INTCTL, 8'h00);
    wr(`REG_OPTION, 8'h40);
    goSleep(1'b1);
    n = 0;
    while (!wk && n < 40) begin
      tick();
      n++;
    end
    chk(n, 18);
    chk(cr, 1'b0);
    expStatus = 'h00;
    rd(`REG_STATUS, expStatus);
    $display("test watchdog wake done");
    for (int i = 0; i < 2; i++) begin
      wr(`REG_OPTION, i ? 8'h49 : 8'h40);
      clrWdtExec <= 1'b1;
      step();
      clrWdtExec <= 1'b0;
      cr = 0;
      n = 0;
      while (!cr && n < 80) begin
        tick();
        n++;
      end
      chk(n, i ? 36 : 18);
    end
    watchdogFuseEnable <= 1'b0;
    cr = 0;
    repeat (40) tick();
    chk(cr, 1'b0);
    $display("test watchdog reset done");
    // brownout resets the core but is no wake source, so power-on wakes it
    for (int i = 0; i < 4; i++) begin
      if (i == 0 || i == 3) goSleep(1'b1);
      wk = 0;
      cr = 0;
      resetPinEnable <= (i != 1);
      case (i)
        0: brownoutReset <= 1'b1;
        2: porEvent <= 1'b1;
        default: externalResetPinN <= 1'b0;
      endcase
      repeat (12) step();
      porEvent <= 1'b0;
      brownoutReset <= 1'b0;
      externalResetPinN <= 1'b1;
      repeat (4) step();
      chk(cr, i != 1);
      chk(wk, 1'b0);
      chk(cpuClkEn, i > 1);
    end
    $display("test reset wake done");
    end_of_test();
  end
endmodule

bind sleep_wake_and_watchdog sleep_wake_properties props_u (.ref_clk,
  .reset, .regRead, .regRdata, .sleepExec, .cpuClkEn, .prefetchNext,
  .wakeResume, .wakeToIsr, .coreReset, .analogSupplyEn, .isrAddr,
  .portOut, .portOeN, .pinOut, .pinOeN);

/* File: test/sleep_wake_properties.sv */
`timescale 1ns/1ns
module sleep_wake_properties (
  // clock and reset
  input wire logic                     ref_clk,
  input wire logic                     reset,
  // register port
  input wire logic                     regRead,
  input wire sleep_wake_pkg::byte_type regRdata,
  // sleep and wake
  input wire logic                     sleepExec,
  input wire logic                     cpuClkEn,
  input wire logic                     prefetchNext,
  input wire logic                     wakeResume,
  input wire logic                     wakeToIsr,
  input wire logic                     coreReset,
  input wire logic                     analogSupplyEn,
  input wire logic [12:0]              isrAddr,
  // pins
  input wire sleep_wake_pkg::byte_type portOut,
  input wire sleep_wake_pkg::byte_type portOeN,
  input wire sleep_wake_pkg::byte_type pinOut,
  input wire sleep_wake_pkg::byte_type pinOeN
);
  import sleep_wake_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  //////////////////////////////////////////////////////////////////////////
  // a taken sleep drops the clock one cycle after the strobe
  sequence tookSleep;
    sleepExec && cpuClkEn ##1 !cpuClkEn;
  endsequence
  sequence stillAsleep;
    !cpuClkEn ##1 !cpuClkEn;
  endsequence
  //////////////////////////////////////////////////////////////////////////
  sleep_cuts_power_a: assert property (
    tookSleep |-> !analogSupplyEn && prefetchNext)
    else $error("analog supply on after sleep entry");
  sleep_prefetch_a: assert property (
    sleepExec && cpuClkEn |=> prefetchNext)
    else $error("no prefetch after sleep");
  clock_stop_cause_a: assert property (
    $fell(cpuClkEn) |-> $past(sleepExec))
    else $error("clock stopped without sleep");
  analog_tracks_a: assert property (
    analogSupplyEn == cpuClkEn)
    else $error("analog supply out of step with sleep");
  pins_frozen_a: assert property (
    stillAsleep |-> $stable(pinOut) && $stable(pinOeN))
    else $error("pins moved while asleep");
  // reset cycle excluded: pins hold reset levels there, not the port
  pins_follow_a: assert property (
    cpuClkEn && $past(cpuClkEn) && !$past(reset)
    |-> pinOut == $past(portOut) && pinOeN == $past(portOeN))
    else $error("pins not following port while running");
  resume_on_wake_a: assert property (
    wakeResume |-> $rose(cpuClkEn) && !coreReset)
    else $error("resume without wake");
  isr_needs_resume_a: assert property (
    wakeToIsr |-> wakeResume)
    else $error("vector request outside wake");
  vector_fixed_a: assert property (
    isrAddr == 13'h0004)
    else $error("wrong service vector");
  read_quiet_a: assert property (
    !$past(regRead) |-> regRdata == 8'h00)
    else $error("read data outside read slot");
endmodule
